// file: rsp_host.sv
// user end: register-driven request sender on an AHB-Lite slave
`timescale 1ns/100ps
module rsp_host (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	// AHB-Lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic [31:0] o_hrdata,
	// interrupt
	output logic o_irq,
	// request stream
	rsp_if.host bus
);
	logic wr_q, wr_d;
	logic [7:0] wa_q;
	logic [31:0] rd_q, rd_d;
	logic [3:0] ctrl_q, hint_ph;
	logic [31:0] hint_q, seed_q;
	logic [3:0] len_q, beat_q;
	logic [1:0] stat_q, mask_q, stat_set;
	logic [5:0] echo_q;
	logic irq_q;
	rsp_pkg::rsp_hst_t st_q;
	logic vld_q, last_q;
	logic [rsp_pkg::DATA_W-1:0] dat_q, dat_d;
	logic [rsp_pkg::SB_W-1:0] sb_q, sb_d;
	logic go, acc, nxt;
	logic [3:0] ctrl_now;

	// odd parity per byte
	function automatic logic [rsp_pkg::PAR_W-1:0] par_gen(input logic [rsp_pkg::DATA_W-1:0] d);
		logic [rsp_pkg::PAR_W-1:0] p;
		p = '0;
		for (int i = 0; i < rsp_pkg::PAR_W; i++) begin
			p[i] = ~(^d[8*i +: 8]);
		end
		return p;
	endfunction : par_gen

	// bus decode
	always_comb begin
		wr_d = i_hsel & i_hready & i_htrans[1] & i_hwrite;
		case (i_haddr[7:0])
			rsp_pkg::A_CTRL: rd_d = {28'h0000000, ctrl_q};
			rsp_pkg::A_HINT: rd_d = hint_q;
			rsp_pkg::A_LEN: rd_d = {28'h0000000, len_q};
			rsp_pkg::A_SEED: rd_d = seed_q;
			rsp_pkg::A_STAT: rd_d = {29'h0, st_q == rsp_pkg::HS_SEND, stat_q};
			rsp_pkg::A_MASK: rd_d = {30'h0, mask_q};
			rsp_pkg::A_ECHO: rd_d = {26'h0, echo_q};
			default: rd_d = rsp_pkg::RST_WORD;
		endcase
	end

	// address phase capture and read data
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			wr_q <= 1'b0;
			wa_q <= 8'h00;
			rd_q <= rsp_pkg::RST_WORD;
		end else begin
			wr_q <= wr_d;
			wa_q <= i_haddr[7:0];
			rd_q <= rd_d;
		end
	end

	assign go = wr_q & (wa_q == rsp_pkg::A_CTRL) & i_hwdata[rsp_pkg::C_GO] & (st_q == rsp_pkg::HS_IDLE);
	assign acc = vld_q & bus.req_stream_ready;
	assign nxt = acc & ~last_q;
	assign hint_ph = hint_q[3:0];
	// settings written together with go already apply to the first beat
	assign ctrl_now = (wr_q && wa_q == rsp_pkg::A_CTRL) ? {i_hwdata[3:1], 1'b0} : ctrl_q;

	// configuration registers
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl_q <= 4'h0;
			hint_q <= rsp_pkg::RST_WORD;
			len_q <= 4'h0;
			seed_q <= rsp_pkg::RST_WORD;
			mask_q <= 2'h0;
		end else if (wr_q) begin
			case (wa_q)
				rsp_pkg::A_CTRL: ctrl_q <= {i_hwdata[3:1], 1'b0};
				rsp_pkg::A_HINT: hint_q <= i_hwdata;
				rsp_pkg::A_LEN: len_q <= i_hwdata[3:0];
				rsp_pkg::A_SEED: seed_q <= i_hwdata;
				rsp_pkg::A_MASK: mask_q <= i_hwdata[1:0];
				default: ;
			endcase
		end
	end

	// sticky events, set wins over clear
	always_comb begin
		stat_set = {bus.req_progress_echo_a_vld, acc & last_q};
	end
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			stat_q <= 2'h0;
			echo_q <= 6'h00;
			irq_q <= 1'b0;
		end else begin
			if (wr_q && wa_q == rsp_pkg::A_STAT) begin
				stat_q <= (stat_q & ~i_hwdata[1:0]) | stat_set;
			end else begin
				stat_q <= stat_q | stat_set;
			end
			if (bus.req_progress_echo_a_vld) begin
				echo_q <= bus.req_progress_echo_a;
			end
			irq_q <= |(stat_q & mask_q);
		end
	end

	// beat contents: fields only on the first beat, single packet
	always_comb begin
		dat_d = {16{seed_q + {28'h0000000, go ? 4'h0 : beat_q + 4'h1}}};
		sb_d = '0;
		sb_d[rsp_pkg::SB_SOP] = go;
		sb_d[rsp_pkg::SB_EOP] = go ? (len_q == 4'h0) : (beat_q + 4'h1 == len_q);
		if (go) begin
			sb_d[rsp_pkg::SB_HINT] = ctrl_now[rsp_pkg::C_TPH];
			sb_d[rsp_pkg::SB_PH +: 2] = hint_ph[1:0];
			sb_d[rsp_pkg::SB_IND] = hint_q[rsp_pkg::H_IND];
			sb_d[rsp_pkg::SB_ST +: 8] = hint_q[rsp_pkg::H_ST +: 8];
			sb_d[rsp_pkg::SB_SEQ0 +: 6] = hint_q[rsp_pkg::H_SEQ +: 6];
		end
		if (ctrl_now[rsp_pkg::C_PAR]) begin
			sb_d[rsp_pkg::SB_PAR +: rsp_pkg::PAR_W] = par_gen(dat_d)
				^ {63'h0, ctrl_now[rsp_pkg::C_BAD]};
		end // else parity left zero
	end

	// send state machine
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			st_q <= rsp_pkg::HS_IDLE;
			vld_q <= 1'b0;
			last_q <= 1'b0;
			beat_q <= 4'h0;
			dat_q <= '0;
			sb_q <= '0;
		end else begin
			case (st_q)
				rsp_pkg::HS_IDLE: begin
					if (go) begin
						st_q <= rsp_pkg::HS_SEND;
						vld_q <= 1'b1;
						last_q <= (len_q == 4'h0);
						beat_q <= 4'h0;
						dat_q <= dat_d;
						sb_q <= sb_d;
					end
				end
				rsp_pkg::HS_SEND: begin
					if (acc && last_q) begin
						st_q <= rsp_pkg::HS_IDLE;
						vld_q <= 1'b0;
						last_q <= 1'b0;
						sb_q <= '0;
					end else if (nxt) begin
						beat_q <= beat_q + 4'h1;
						last_q <= (beat_q + 4'h1 == len_q);
						dat_q <= dat_d;
						sb_q <= sb_d;
					end
				end
				default: st_q <= rsp_pkg::HS_IDLE;
			endcase
		end
	end

	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_hrdata = rd_q;
	assign o_irq = irq_q;
	assign bus.req_stream_valid = vld_q;
	assign bus.req_stream_last = last_q;
	assign bus.req_stream_data = dat_q;
	assign bus.req_stream_sideband = sb_q;
endmodule : rsp_host

// file: rsp_pkg.sv
// shared constants and types for the request sideband link
package rsp_pkg;
	// sideband layout
	localparam int SB_W = 137;
	localparam int DATA_W = 512;
	localparam int PAR_W = 64;
	localparam int SB_SOP = 20;
	localparam int SB_SOP1_PTR = 24;
	localparam int SB_EOP = 26;
	localparam int SB_HINT = 37;
	localparam int SB_PH = 39;
	localparam int SB_IND = 43;
	localparam int SB_ST = 45;
	localparam int SB_SEQ0 = 61;
	localparam int SB_SEQ1 = 67;
	localparam int SB_PAR = 73;
	localparam logic [1:0] LANE32 = 2'h2;
	localparam int SEQ_W = 6;
	localparam int ST_W = 8;
	// host register offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_HINT = 8'h04;
	localparam logic [7:0] A_LEN = 8'h08;
	localparam logic [7:0] A_SEED = 8'h0C;
	localparam logic [7:0] A_STAT = 8'h10;
	localparam logic [7:0] A_MASK = 8'h14;
	localparam logic [7:0] A_ECHO = 8'h18;
	// field positions
	localparam int C_GO = 0;
	localparam int C_PAR = 1;
	localparam int C_TPH = 2;
	localparam int C_BAD = 3;
	localparam int H_IND = 2;
	localparam int H_ST = 8;
	localparam int H_SEQ = 16;
	localparam int S_SENT = 0;
	localparam int S_ECHO = 1;
	localparam int S_BUSY = 2;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	// captured per-packet sideband
	typedef struct packed {
		logic hint;
		logic [1:0] ph;
		logic ind;
		logic [ST_W-1:0] st;
		logic [SEQ_W-1:0] seq;
		logic perr;
	} rsp_desc_t;
	// request handed to the transmit side
	typedef struct packed {
		logic vld;
		logic hint;
		logic [1:0] ph;
		logic [ST_W-1:0] st;
		logic [SEQ_W-1:0] seq;
		logic nullify;
	} rsp_req_t;
	typedef enum logic [0:0] {HS_IDLE, HS_SEND} rsp_hst_t;
endpackage : rsp_pkg

// file: rsp_if.sv
// request stream link between user logic and the core
`timescale 1ns/100ps
interface rsp_if;
	logic req_stream_valid;
	logic req_stream_ready;
	logic req_stream_last;
	logic [rsp_pkg::DATA_W-1:0] req_stream_data;
	logic [rsp_pkg::SB_W-1:0] req_stream_sideband;
	logic req_progress_echo_a_vld;
	logic req_progress_echo_b_vld;
	logic [rsp_pkg::SEQ_W-1:0] req_progress_echo_a;
	logic [rsp_pkg::SEQ_W-1:0] req_progress_echo_b;
	// core end
	modport dev (
		input req_stream_valid, req_stream_last, req_stream_data, req_stream_sideband,
		output req_stream_ready, req_progress_echo_a_vld, req_progress_echo_b_vld,
		output req_progress_echo_a, req_progress_echo_b
	);
	// user logic end
	modport host (
		output req_stream_valid, req_stream_last, req_stream_data, req_stream_sideband,
		input req_stream_ready, req_progress_echo_a_vld, req_progress_echo_b_vld,
		input req_progress_echo_a, req_progress_echo_b
	);
endinterface : rsp_if

// file: rsp_dev.sv
// core end: sideband capture, tag resolution, parity check, echo
// Contract
// - hint-present bit per starting packet
// - capture sideband on first accepted beat
// - user holds hint-present zero when unused
// - two-bit PH slice per packet
// - ignore hint fields when hint absent
// - indirect: tag indexes steering table
// - direct: tag passed through unchanged
// - eight-bit steering tag per packet
// - echo first sequence number when committed
// - second sequence number handled identically
// - user may tie sequence inputs zero
// - user drives odd parity per byte
// - parity error nullifies, reports uncorrectable
// - parity may be zero when disabled
// - second packet needs straddle, lane 32
`timescale 1ns/100ps
module rsp_dev #(
	parameter int ST_DEPTH = 64,
	parameter bit STRADDLE = 1'b1
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	// request stream
	rsp_if.dev bus,
	// configuration
	input wire logic i_par_en,
	// steering table load
	input wire logic i_st_wr,
	input wire logic [$clog2(ST_DEPTH)-1:0] i_st_addr,
	input wire logic [rsp_pkg::ST_W-1:0] i_st_data,
	// resolved requests and errors
	output rsp_pkg::rsp_req_t o_req_a,
	output rsp_pkg::rsp_req_t o_req_b,
	output logic o_uncorr_err
);
	localparam int IDX_W = $clog2(ST_DEPTH);

	logic [rsp_pkg::ST_W-1:0] st_tab [ST_DEPTH];
	logic ready_q;
	logic open_q, open_d;
	rsp_pkg::rsp_desc_t cur_q, cur_d;
	rsp_pkg::rsp_req_t req_a_q, req_b_q, req_a_d, req_b_d;
	logic err_q;
	logic ea_vld_q, eb_vld_q;
	logic [rsp_pkg::SEQ_W-1:0] ea_q, eb_q;
	logic acc, berr, s0, s1, e0, e1;
	logic [1:0] n_end, n_cand;
	rsp_pkg::rsp_desc_t cand [3];
	logic [rsp_pkg::SB_W-1:0] sb;

	assign sb = bus.req_stream_sideband;
	assign acc = bus.req_stream_valid & ready_q;

	// odd parity check over all data bytes
	function automatic logic par_bad(input logic [rsp_pkg::DATA_W-1:0] d,
		input logic [rsp_pkg::PAR_W-1:0] p);
		logic bad;
		bad = 1'b0;
		for (int i = 0; i < rsp_pkg::PAR_W; i++) begin
			bad = bad | ~(^{d[8*i +: 8], p[i]});
		end
		return bad;
	endfunction : par_bad

	// slice sideband fields for starting packet k
	function automatic rsp_pkg::rsp_desc_t slice(input logic [rsp_pkg::SB_W-1:0] s,
		input int k);
		rsp_pkg::rsp_desc_t r;
		r.hint = s[rsp_pkg::SB_HINT + k];
		r.ph = s[rsp_pkg::SB_PH + 2*k +: 2];
		r.ind = s[rsp_pkg::SB_IND + k];
		r.st = s[rsp_pkg::SB_ST + 8*k +: 8];
		r.seq = (k == 0) ? s[rsp_pkg::SB_SEQ0 +: 6] : s[rsp_pkg::SB_SEQ1 +: 6];
		r.perr = 1'b0;
		return r;
	endfunction : slice

	// resolve tag and hide unused hint fields
	function automatic rsp_pkg::rsp_req_t resolve(input rsp_pkg::rsp_desc_t c,
		input logic [rsp_pkg::ST_W-1:0] tab_val);
		rsp_pkg::rsp_req_t r;
		r.vld = 1'b1;
		r.hint = c.hint;
		r.ph = c.hint ? c.ph : 2'h0;
		r.st = 8'h00;
		if (c.hint) begin
			r.st = c.ind ? tab_val : c.st;
		end
		r.seq = c.seq;
		r.nullify = c.perr;
		return r;
	endfunction : resolve

	// starts and ends seen in this beat
	always_comb begin
		berr = i_par_en & par_bad(bus.req_stream_data, sb[rsp_pkg::SB_PAR +: rsp_pkg::PAR_W]);
		s0 = sb[rsp_pkg::SB_SOP];
		s1 = STRADDLE & sb[rsp_pkg::SB_SOP + 1]
			& (sb[rsp_pkg::SB_SOP1_PTR +: 2] == rsp_pkg::LANE32);
		e0 = STRADDLE ? sb[rsp_pkg::SB_EOP] : bus.req_stream_last;
		e1 = STRADDLE & sb[rsp_pkg::SB_EOP + 1];
		n_end = {1'b0, e0} + {1'b0, e1};
	end

	// order packets touching the beat: open one, then new starts
	always_comb begin
		cand[0] = '0;
		cand[1] = '0;
		cand[2] = '0;
		n_cand = 2'h0;
		if (open_q) begin
			cand[n_cand] = cur_q;
			cand[n_cand].perr = cur_q.perr | berr;
			n_cand = n_cand + 2'h1;
		end
		if (s0) begin
			cand[n_cand] = slice(sb, 0);
			cand[n_cand].perr = berr;
			n_cand = n_cand + 2'h1;
		end
		if (s1) begin
			cand[n_cand] = slice(sb, 1);
			cand[n_cand].perr = berr;
			n_cand = n_cand + 2'h1;
		end
	end

	// next open packet and finished requests
	always_comb begin
		open_d = open_q;
		cur_d = cur_q;
		req_a_d = '0;
		req_b_d = '0;
		if (acc) begin
			if (n_end >= 2'h1 && n_cand >= 2'h1) begin
				req_a_d = resolve(cand[0], st_tab[cand[0].st[IDX_W-1:0]]);
			end
			if (n_end >= 2'h2 && n_cand >= 2'h2) begin
				req_b_d = resolve(cand[1], st_tab[cand[1].st[IDX_W-1:0]]);
			end
			if (n_cand > n_end) begin
				open_d = 1'b1;
				cur_d = cand[n_end];
			end else begin
				open_d = 1'b0;
			end
		end
	end

	// steering table writes
	always_ff @(posedge i_clk_sys) begin
		if (i_st_wr) begin
			st_tab[i_st_addr] <= i_st_data;
		end
	end

	// stream ready, open packet state
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			ready_q <= 1'b0;
			open_q <= 1'b0;
			cur_q <= '0;
		end else begin
			ready_q <= 1'b1;
			open_q <= open_d;
			cur_q <= cur_d;
		end
	end

	// resolved requests and error pulse
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			req_a_q <= '0;
			req_b_q <= '0;
			err_q <= 1'b0;
		end else begin
			req_a_q <= req_a_d;
			req_b_q <= req_b_d;
			err_q <= req_a_d.nullify | req_b_d.nullify;
		end
	end

	// progress echo once the request has left the pipeline
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			ea_vld_q <= 1'b0;
			eb_vld_q <= 1'b0;
			ea_q <= 6'h00;
			eb_q <= 6'h00;
		end else begin
			ea_vld_q <= req_a_q.vld;
			eb_vld_q <= req_b_q.vld;
			ea_q <= req_a_q.seq;
			eb_q <= req_b_q.seq;
		end
	end

	assign bus.req_stream_ready = ready_q;
	assign bus.req_progress_echo_a_vld = ea_vld_q;
	assign bus.req_progress_echo_b_vld = eb_vld_q;
	assign bus.req_progress_echo_a = ea_q;
	assign bus.req_progress_echo_b = eb_q;
	assign o_req_a = req_a_q;
	assign o_req_b = req_b_q;
	assign o_uncorr_err = err_q;
endmodule : rsp_dev

// file: rsp_chk.sv
// assertions on the request stream link between the two ends
`timescale 1ns/100ps
module rsp_chk (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	// request stream
	input wire logic req_stream_valid,
	input wire logic req_stream_ready,
	input wire logic req_stream_last,
	input wire logic [rsp_pkg::DATA_W-1:0] req_stream_data,
	input wire logic [rsp_pkg::SB_W-1:0] req_stream_sideband,
	// progress echo
	input wire logic req_progress_echo_a_vld,
	input wire logic req_progress_echo_b_vld,
	input wire logic [rsp_pkg::SEQ_W-1:0] req_progress_echo_a,
	input wire logic [rsp_pkg::SEQ_W-1:0] req_progress_echo_b
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);
	logic beat;
	logic sop;
	logic eop;
	logic in_pkt_q;
	logic [rsp_pkg::SEQ_W-1:0] seq_q;
	logic [rsp_pkg::PAR_W-1:0] par_calc;
	// accepted beat and its framing bits
	assign beat = req_stream_valid & req_stream_ready;
	assign sop = req_stream_sideband[rsp_pkg::SB_SOP];
	assign eop = req_stream_sideband[rsp_pkg::SB_EOP];
	// odd parity of every data byte
	always_comb begin
		for (int i = 0; i < rsp_pkg::PAR_W; i++) begin
			par_calc[i] = ~^req_stream_data[8*i +: 8];
		end
	end
	// open packet tracking
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			in_pkt_q <= 1'b0;
		end else if (beat) begin
			in_pkt_q <= ~eop;
		end
	end
	// sequence number of the last started packet
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			seq_q <= 6'h00;
		end else if (beat && sop) begin
			seq_q <= req_stream_sideband[rsp_pkg::SB_SEQ0 +: rsp_pkg::SEQ_W];
		end
	end
	ready_after_reset_a: assert property ($past(i_nrst) |-> req_stream_ready)
		else $error("stream ready low after reset");
	start_not_mid_a: assert property (beat && in_pkt_q |-> !sop)
		else $error("start flag inside an open packet");
	start_after_end_a: assert property (beat && !in_pkt_q |-> sop)
		else $error("beat outside a packet without start flag");
	second_start_off_a: assert property (req_stream_valid |-> !req_stream_sideband[21])
		else $error("second start flagged by slot-0 sender");
	last_flag_a: assert property (req_stream_valid |-> req_stream_last == eop)
		else $error("last flag disagrees with end flag");
	later_beats_zero_a: assert property (beat && !sop |->
		req_stream_sideband[rsp_pkg::SB_HINT +: 36] == 36'h0)
		else $error("hint or sequence fields on a later beat");
	parity_odd_a: assert property (req_stream_valid &&
		req_stream_sideband[rsp_pkg::SB_PAR +: rsp_pkg::PAR_W] != 64'h0 |->
		req_stream_sideband[rsp_pkg::SB_PAR+1 +: 63] == par_calc[63:1])
		else $error("byte parity is not odd");
	echo_timing_a: assert property (beat && eop |-> ##2 req_progress_echo_a_vld)
		else $error("echo missing two cycles after packet end");
	echo_cause_a: assert property (req_progress_echo_a_vld |-> $past(beat && eop, 2))
		else $error("echo without a finished packet");
	echo_value_a: assert property (req_progress_echo_a_vld |-> req_progress_echo_a == seq_q)
		else $error("echo differs from captured sequence");
	echo_second_a: assert property (req_progress_echo_b_vld |->
		$past(req_stream_sideband[rsp_pkg::SB_EOP+1], 2))
		else $error("second echo without a second packet");
	single_beat_c: cover property (beat && sop && eop);
	multi_beat_c: cover property (beat && !sop);
	echo_seen_c: cover property (req_progress_echo_a_vld);
endmodule : rsp_chk

// file: request_sideband_tph_seq_parity_bench.sv
// self-checking bench: register-driven sender and core joined by the stream
`timescale 1ns/100ps
module request_sideband_tph_seq_parity_bench;
	logic i_clk_sys = 1'b0;
	logic i_nrst = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic par_en = 1'b0;
	logic st_wr = 1'b0;
	logic [5:0] st_addr = 6'h00;
	logic [7:0] st_data = 8'h00;
	logic [1:0] msk = 2'h0;
	logic hready;
	logic hresp;
	logic irq;
	logic uncorr_err;
	logic [31:0] hrdata;
	logic [31:0] rd;
	rsp_pkg::rsp_req_t req_a;
	rsp_pkg::rsp_req_t req_b;
	rsp_pkg::rsp_req_t got_req;
	int num_errors = 0;
	int compares = 0;
	int got_n = 0;
	int err_n = 0;
	int cyc = 0;
	rsp_if rsp_if_inst ();
	rsp_host rsp_host_inst (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
		.i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp),
		.o_hrdata(hrdata), .o_irq(irq), .bus(rsp_if_inst));
	rsp_dev rsp_dev_inst (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .bus(rsp_if_inst),
		.i_par_en(par_en), .i_st_wr(st_wr), .i_st_addr(st_addr), .i_st_data(st_data),
		.o_req_a(req_a), .o_req_b(req_b), .o_uncorr_err(uncorr_err));
	rsp_chk rsp_chk_inst (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
		.req_stream_valid(rsp_if_inst.req_stream_valid),
		.req_stream_ready(rsp_if_inst.req_stream_ready),
		.req_stream_last(rsp_if_inst.req_stream_last),
		.req_stream_data(rsp_if_inst.req_stream_data),
		.req_stream_sideband(rsp_if_inst.req_stream_sideband),
		.req_progress_echo_a_vld(rsp_if_inst.req_progress_echo_a_vld),
		.req_progress_echo_b_vld(rsp_if_inst.req_progress_echo_b_vld),
		.req_progress_echo_a(rsp_if_inst.req_progress_echo_a),
		.req_progress_echo_b(rsp_if_inst.req_progress_echo_b));
	// free-running clock
	always #20 i_clk_sys = ~i_clk_sys;
	// record resolved requests, error pulses and elapsed cycles
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
		if (req_a.vld === 1'b1) begin
			got_req <= req_a;
			got_n <= got_n + 1;
		end
		if (uncorr_err === 1'b1) begin
			err_n <= err_n + 1;
		end
		if (cyc == 20000) begin
			num_errors = num_errors + 1;
			wrap_up();
		end
	end
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		compares = compares + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_word
	task automatic chk_req(input rsp_pkg::rsp_req_t got, input rsp_pkg::rsp_req_t exp);
		chk_word({13'h0, got}, {13'h0, exp});
	endtask : chk_req
	function automatic rsp_pkg::rsp_req_t mk(input logic h, input logic [1:0] ph,
		input logic [7:0] st, input logic [5:0] seq, input logic nul);
		mk = {1'b1, h, ph, st, seq, nul};
	endfunction : mk
	// one single AHB-Lite transfer; read data lands in rd
	task automatic ahb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
		@(posedge i_clk_sys);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, addr};
		hwrite <= wr;
		do @(posedge i_clk_sys); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge i_clk_sys); while (hready !== 1'b1);
		rd = hrdata;
	endtask : ahb_xfer
	// send one packet, then check request, error, echo, status and interrupt
	task automatic run_pkt(input logic [3:0] ctrl, input logic [31:0] hint, input logic [3:0] len,
		input logic pe, input rsp_pkg::rsp_req_t exp);
		int n0;
		int e0;
		int w;
		par_en <= pe;
		ahb_xfer(1'b1, rsp_pkg::A_HINT, hint);
		ahb_xfer(1'b1, rsp_pkg::A_LEN, {28'h0, len});
		ahb_xfer(1'b1, rsp_pkg::A_SEED, hint ^ 32'h1357_9BDF);
		n0 = got_n;
		e0 = err_n;
		ahb_xfer(1'b1, rsp_pkg::A_CTRL, {28'h0, ctrl});
		w = 0;
		while (got_n == n0 && w < 100) begin
			@(posedge i_clk_sys);
			w++;
		end
		repeat (3) @(posedge i_clk_sys);
		chk_req(got_req, exp);
		chk_req(req_b, '0);
		chk_word(32'(err_n - e0), {31'h0, exp.nullify});
		ahb_xfer(1'b0, rsp_pkg::A_ECHO, 32'h0);
		chk_word(rd, {26'h0, exp.seq});
		ahb_xfer(1'b0, rsp_pkg::A_STAT, 32'h0);
		chk_word(rd, 32'h0000_0003);
		chk_word({31'h0, irq}, {31'h0, |msk});
		ahb_xfer(1'b1, rsp_pkg::A_STAT, 32'h0000_0003);
		repeat (2) @(posedge i_clk_sys);
		chk_word({31'h0, irq}, 32'h0);
		$display("packet test done, ctrl %h hint %h", ctrl, hint);
	endtask : run_pkt
	task automatic set_mask(input logic [1:0] m);
		msk = m;
		ahb_xfer(1'b1, rsp_pkg::A_MASK, {30'h0, m});
		ahb_xfer(1'b0, rsp_pkg::A_MASK, 32'h0);
		chk_word(rd, {30'h0, m});
	endtask : set_mask
	task automatic wrap_up();
		$display("compares %0d, mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : wrap_up
	// main sequence
	initial begin
		repeat (16) @(posedge i_clk_sys);
		i_nrst <= 1'b1;
		for (int a = 0; a < 8; a++) begin
			ahb_xfer(1'b0, 8'(4 * a), 32'h0);
			chk_word(rd, rsp_pkg::RST_WORD);
			chk_word({31'h0, hresp}, 32'h0);
		end
		ahb_xfer(1'b1, 8'h1C, 32'hFFFF_FFFF);
		ahb_xfer(1'b0, 8'h1C, 32'h0);
		chk_word(rd, 32'h0);
		$display("register test done");
		@(posedge i_clk_sys);
		st_wr <= 1'b1;
		st_addr <= 6'h05;
		st_data <= 8'hC3;
		@(posedge i_clk_sys);
		st_wr <= 1'b0;
		set_mask(2'h0);
		run_pkt(4'h7, 32'h002B_5A02, 4'h0, 1'b1, mk(1'b1, 2'h2, 8'h5A, 6'h2B, 1'b0));
		set_mask(2'h1);
		run_pkt(4'h7, 32'h0011_C505, 4'h3, 1'b1, mk(1'b1, 2'h1, 8'hC3, 6'h11, 1'b0));
		set_mask(2'h2);
		run_pkt(4'h3, 32'h003F_FF07, 4'h1, 1'b1, mk(1'b0, 2'h0, 8'h00, 6'h3F, 1'b0));
		run_pkt(4'hF, 32'h0001_0000, 4'h1, 1'b1, mk(1'b1, 2'h0, 8'h00, 6'h01, 1'b1));
		run_pkt(4'h5, 32'h0000_0103, 4'h0, 1'b0, mk(1'b1, 2'h3, 8'h01, 6'h00, 1'b0));
		wrap_up();
	end
endmodule : request_sideband_tph_seq_parity_bench
